// file: core/stdc_half_rate.sv
`timescale 1ns/1ps
`default_nettype none

// Enable pulse on every second system clock, the half-rate reference
module stdc_half_rate (
    input  wire logic SYS_CLK,
    input  wire logic RST_N,
    output var  logic HALF_EN
);

    logic phase_r;

    // Phase toggle and pulse register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            phase_r <= 1'b0;
            HALF_EN <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            HALF_EN <= phase_r;
        end
    end

endmodule

`default_nettype wire

// file: core/stdc_pkg.sv
package stdc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] OFF_CTRL_STATUS = 12'h010;
    localparam logic [11:0] OFF_RELOAD      = 12'h014;
    localparam logic [11:0] OFF_CURRENT     = 12'h018;
    localparam logic [11:0] OFF_CALIB       = 12'h01c;

    // ************************************************************
    // Field positions and widths
    // ************************************************************
    localparam int          CNT_W           = 24;
    localparam int          BIT_ENABLE      = 0;
    localparam int          BIT_TICK_IE     = 1;
    localparam int          BIT_CLK_SEL     = 2;
    localparam int          BIT_ZERO_FLAG   = 16;
    localparam int          BIT_CAL_CALIBRATION_INDICATOR_A    = 30;
    localparam int          BIT_CAL_NO_REFERENCE_CLOCK_INDICATOR   = 31;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0]  RST_CTRL        = 3'h0;
    localparam logic [23:0] RST_RELOAD      = 24'h000000;
    localparam logic [23:0] RST_CURRENT     = 24'h000000;
    localparam logic [31:0] RST_CALIB       = 32'h00000004;

endpackage

// file: core/stdc_top.sv
`timescale 1ns/1ps
`default_nettype none

module stdc_top (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic [31:0] CAL_IN,
    output var  logic [31:0] REG_RDATA,
    output var  logic        TICK_IRQ
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [2:0]                    ctrl_r;
    logic [stdc_pkg::CNT_W-1:0]    reload_r;
    logic [stdc_pkg::CNT_W-1:0]    cnt_r;
    logic [stdc_pkg::CNT_W-1:0]    cnt_nxt;
    logic                          zero_flag_r;
    logic [31:0]                   cal_r;
    logic                          half_en;
    logic                          tick;
    logic                          hit_zero;
    logic                          wr_ctrl;
    logic                          wr_reload;
    logic                          wr_cur;
    logic                          rd_ctrl;

    // Address match for one register word
    function automatic logic sel(input logic [11:0] a,
                                 input logic [11:0] off);
        sel = (a == off);
    endfunction

    // ************************************************************
    // Count rate and decode
    // ************************************************************
    stdc_half_rate u_half (
        .SYS_CLK (SYS_CLK),
        .RST_N   (RST_N),
        .HALF_EN (half_en)
    );

    // Counting step qualifiers and register strobes
    assign tick      = ctrl_r[stdc_pkg::BIT_ENABLE] &&
                       (ctrl_r[stdc_pkg::BIT_CLK_SEL] || half_en);
    assign hit_zero  = tick && (cnt_r == 24'h000001);
    assign wr_ctrl   = REG_WR && sel(REG_ADDR, stdc_pkg::OFF_CTRL_STATUS);
    assign wr_reload = REG_WR && sel(REG_ADDR, stdc_pkg::OFF_RELOAD);
    assign wr_cur    = REG_WR && sel(REG_ADDR, stdc_pkg::OFF_CURRENT);
    assign rd_ctrl   = REG_RD && sel(REG_ADDR, stdc_pkg::OFF_CTRL_STATUS);

    // ************************************************************
    // Registers written by software, and the calibration copy
    // ************************************************************
    // Control bits and reload value, reserved bits not stored
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_r   <= stdc_pkg::RST_CTRL;
            reload_r <= stdc_pkg::RST_RELOAD;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= REG_WDATA[2:0];
            end
            if (wr_reload) begin
                reload_r <= REG_WDATA[23:0];
            end
        end
    end

    // Calibration tracks the external source, writes ignored
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cal_r <= stdc_pkg::RST_CALIB;
        end else begin
            cal_r <= CAL_IN;
        end
    end

    // ************************************************************
    // Down counter
    // ************************************************************
    // Next count: clear on write, reload at zero, else step down
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_cur) begin
            cnt_nxt = '0;
        end else if (tick) begin
            if (cnt_r == '0) begin
                cnt_nxt = reload_r;
            end else begin
                cnt_nxt = cnt_r - 24'h000001;
            end
        end
    end

    // Counter register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cnt_r <= stdc_pkg::RST_CURRENT;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Zero flag: a new zero wins over a read clear, a write clear wins over a new zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            zero_flag_r <= 1'b0;
        end else if (hit_zero && !wr_cur) begin
            zero_flag_r <= 1'b1;
        end else if (rd_ctrl || wr_cur) begin
            zero_flag_r <= 1'b0;
        end
    end

    // Interrupt request pulse on each count to zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            TICK_IRQ <= 1'b0;
        end else begin
            TICK_IRQ <= hit_zero && !wr_cur &&
                        ctrl_r[stdc_pkg::BIT_TICK_IE];
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Read data registered, reserved and unmapped read zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            REG_RDATA <= 32'h00000000;
            if (sel(REG_ADDR, stdc_pkg::OFF_CTRL_STATUS)) begin
                REG_RDATA[2:0] <= ctrl_r;
                REG_RDATA[stdc_pkg::BIT_ZERO_FLAG] <= zero_flag_r;
            end else if (sel(REG_ADDR, stdc_pkg::OFF_RELOAD)) begin
                REG_RDATA[23:0] <= reload_r;
            end else if (sel(REG_ADDR, stdc_pkg::OFF_CURRENT)) begin
                REG_RDATA[23:0] <= cnt_r;
            end else if (sel(REG_ADDR, stdc_pkg::OFF_CALIB)) begin
                REG_RDATA[23:0] <= cal_r[23:0];
                REG_RDATA[stdc_pkg::BIT_CAL_CALIBRATION_INDICATOR_A] <=
                    cal_r[stdc_pkg::BIT_CAL_CALIBRATION_INDICATOR_A];
                REG_RDATA[stdc_pkg::BIT_CAL_NO_REFERENCE_CLOCK_INDICATOR] <=
                    cal_r[stdc_pkg::BIT_CAL_NO_REFERENCE_CLOCK_INDICATOR];
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_stop_holds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (!ctrl_r[0] && !wr_cur) |=> (cnt_r == $past(cnt_r)))
        else $error("Stopped counter changed");

    a_irq_gated: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        TICK_IRQ |-> $past(ctrl_r[1]) && $past(cnt_r) == 24'h000001)
        else $error("Request without enable or zero step");

    a_irq_on_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (hit_zero && ctrl_r[1] && !wr_cur) |=> TICK_IRQ ##1 !TICK_IRQ)
        else $error("Missing single-cycle request at zero");

    a_half_rate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ctrl_r[0] && !ctrl_r[2] && !half_en && !wr_cur)
        |=> (cnt_r == $past(cnt_r)))
        else $error("Half-rate count stepped on idle phase");

    a_flag_set: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (hit_zero && !wr_cur) |=> zero_flag_r)
        else $error("Zero flag not set");

    a_reload_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (tick && cnt_r == '0 && !wr_cur && !wr_reload)
        |=> (cnt_r == $past(reload_r)))
        else $error("Reload not taken at zero");

    a_read_count: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (REG_RD && REG_ADDR == stdc_pkg::OFF_CURRENT)
        |=> (REG_RDATA == {8'h00, $past(cnt_r)}))
        else $error("Current value read wrong");

    a_write_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr_cur |=> (cnt_r == '0 && !zero_flag_r))
        else $error("Write to current value did not clear");

    a_cal_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        RST_N |=> (cal_r == $past(CAL_IN)))
        else $error("Calibration not following source");

    a_reset_vals: assert property (@(posedge SYS_CLK)
        !RST_N |=> (ctrl_r == stdc_pkg::RST_CTRL &&
                    cnt_r == stdc_pkg::RST_CURRENT &&
                    cal_r == stdc_pkg::RST_CALIB))
        else $error("Reset values wrong");

endmodule

`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic        SYS_CLK   = 1'b0;
    logic        RST_N     = 1'b0;
    logic [11:0] REG_ADDR  = 12'h000;
    logic        REG_WR    = 1'b0;
    logic        REG_RD    = 1'b0;
    logic [31:0] REG_WDATA = 32'h00000000;
    logic [31:0] CAL_IN    = 32'h00000004;
    logic [31:0] REG_RDATA;
    logic        TICK_IRQ;
    int          fails     = 0;
    int          checks    = 0;
    logic [31:0] v;
    logic [31:0] w;
    int          n;

    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
    } stdc_row_type;

    // Write, then read back through the used-bit mask
    stdc_row_type rows [7] = '{
        '{12'h014, 32'h00123456, 32'h00ffffff, 32'h00123456},
        '{12'h010, 32'h00000004, 32'h00010007, 32'h00000004},
        '{12'h010, 32'h00000002, 32'h00010007, 32'h00000002},
        '{12'h01c, 32'h00000000, 32'hc0ffffff, 32'hc0a5a5a5},
        '{12'h020, 32'h00000005, 32'hffffffff, 32'h00000000},
        '{12'h018, 32'h00000055, 32'h00ffffff, 32'h00000000},
        '{12'h010, 32'h00000000, 32'h00000007, 32'h00000000}
    };

    stdc_top u_dut (
        .SYS_CLK   (SYS_CLK),
        .RST_N     (RST_N),
        .REG_ADDR  (REG_ADDR),
        .REG_WR    (REG_WR),
        .REG_RD    (REG_RD),
        .REG_WDATA (REG_WDATA),
        .CAL_IN    (CAL_IN),
        .REG_RDATA (REG_RDATA),
        .TICK_IRQ  (TICK_IRQ)
    );

    // 50 MHz clock
    initial begin
        forever #10 SYS_CLK = ~SYS_CLK;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD   <= 1'b0;
        #1 d = REG_RDATA;
    endtask

    // Cycles from one request pulse to the next, bounded
    task automatic gap(output int g);
        g = 0;
        while (TICK_IRQ !== 1'b1 && g < 200) begin
            @(posedge SYS_CLK);
            #1 g++;
        end
        g = 0;
        do begin
            @(posedge SYS_CLK);
            #1 g++;
        end while (TICK_IRQ !== 1'b1 && g < 200);
    endtask

    task automatic close_out;
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        fails++;
        close_out();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        rd(12'h010, v); chk("csr_reset", 32'h0, v & 32'h00010007);
        rd(12'h014, v); chk("rvr_reset", 32'h0, v & 32'h00ffffff);
        rd(12'h018, v); chk("cvr_reset", 32'h0, v & 32'h00ffffff);
        rd(12'h01c, v); chk("cal_reset", 32'h4, v & 32'hc0ffffff);
        @(posedge SYS_CLK);
        CAL_IN <= 32'hc0a5a5a5;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("row", rows[i].e, v & rows[i].m);
        end
        // Calibration count copied into reload, reserved bits kept clear
        rd(12'h01c, v);
        wr(12'h014, v & 32'h00ffffff);
        rd(12'h014, w); chk("cal_copy", 32'h00a5a5a5, w);
        // Periodic ticks on the full clock, then on the half rate
        wr(12'h014, 32'h00000003);
        wr(12'h018, 32'h00000000);
        wr(12'h010, 32'h00000007);
        gap(n); chk("gap_full", 32'd4, n);
        wr(12'h010, 32'h00000003);
        gap(n); chk("gap_half", 32'd8, n);
        // Request gated off while counting continues
        wr(12'h010, 32'h00000005);
        n = 0;
        repeat (30) begin
            @(posedge SYS_CLK);
            #1 n += (TICK_IRQ === 1'b1);
        end
        chk("irq_gated", 32'd0, n);
        rd(12'h010, v); chk("flag_set", 32'h10005, v & 32'h10007);
        wr(12'h010, 32'h00000000);
        rd(12'h010, v); rd(12'h010, v);
        chk("flag_clr", 32'h0, v & 32'h10007);
        // Live count, hold while stopped, clear by write
        wr(12'h014, 32'h00000100);
        wr(12'h018, 32'h00000000);
        wr(12'h010, 32'h00000005);
        repeat (10) @(posedge SYS_CLK);
        rd(12'h018, v);
        rd(12'h018, w); chk("live", 32'h1, {31'h0, w < v});
        wr(12'h010, 32'h00000004);
        rd(12'h018, v);
        repeat (10) @(posedge SYS_CLK);
        rd(12'h018, w); chk("hold", v, w);
        wr(12'h010, 32'h00000005);
        repeat (4) @(posedge SYS_CLK);
        rd(12'h018, w); chk("resume", 32'h1, {31'h0, w < v});
        wr(12'h010, 32'h00000004);
        wr(12'h014, 32'h00000002);
        wr(12'h018, 32'h00000000);
        wr(12'h010, 32'h00000005);
        repeat (4) @(posedge SYS_CLK);
        wr(12'h010, 32'h00000004);
        wr(12'h018, 32'h00000077);
        rd(12'h010, v); chk("cvr_wr_flag", 32'h0, v & 32'h10000);
        rd(12'h018, v); chk("cvr_wr_cnt", 32'h0, v & 32'hffffff);
        // Reset in mid-run while ticking with requests on
        wr(12'h014, 32'h00000002);
        wr(12'h010, 32'h00000007);
        repeat (5) @(posedge SYS_CLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        n = 0;
        repeat (6) begin
            @(posedge SYS_CLK);
            #1 n += (TICK_IRQ === 1'b1);
        end
        chk("irq_rerst", 32'd0, n);
        rd(12'h010, v); chk("csr_rerst", 32'h0, v & 32'h00010007);
        rd(12'h014, v); chk("rvr_rerst", 32'h0, v & 32'h00ffffff);
        rd(12'h018, v); chk("cvr_rerst", 32'h0, v & 32'h00ffffff);
        close_out();
    end
endmodule

`default_nettype wire
